// [panel_cfg_pkg.sv]
// panel configuration command decoder: shared constants and types
// assumes an apb master with 32-bit data and one word per register
package panel_cfg_pkg;

    // --------------------------------------------------------------
    // register map (byte addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] OFF_CMD = 8'h00;      // write: command or parameter byte
    localparam logic [7:0] OFF_CFG0 = 8'h04;     // read: start line, mux, offset
    localparam logic [7:0] OFF_CFG1 = 8'h08;     // read: flags, clock, pre-charge
    localparam logic [7:0] OFF_STAT = 8'h0C;     // read: decoder state

    // --------------------------------------------------------------
    // opcodes
    // --------------------------------------------------------------
    localparam logic [7:0] OP_START_LO = 8'h40;  // start line range low end
    localparam logic [7:0] OP_START_HI = 8'h7F;  // start line range high end
    localparam logic [7:0] OP_SEG_NORM = 8'hA0;  // segment map normal
    localparam logic [7:0] OP_SEG_REV = 8'hA1;   // segment map reversed
    localparam logic [7:0] OP_MUX = 8'hA8;       // multiplex ratio
    localparam logic [7:0] OP_SCAN_UP = 8'hC0;   // common scan upward
    localparam logic [7:0] OP_SCAN_DN = 8'hC8;   // common scan downward
    localparam logic [7:0] OP_OFFSET = 8'hD3;    // vertical offset
    localparam logic [7:0] OP_COMPINS = 8'hDA;   // common pin layout
    localparam logic [7:0] OP_CLKDIV = 8'hD5;    // divider and oscillator trim
    localparam logic [7:0] OP_PRECHG = 8'hD9;    // pre-charge phases

    // --------------------------------------------------------------
    // field positions and limits
    // --------------------------------------------------------------
    localparam int ALT_BIT = 4;                  // layout select in pin parameter
    localparam int SWAP_BIT = 5;                 // left/right swap in pin parameter
    localparam logic [5:0] MUX_MIN_VALID = 6'h0F; // lowest accepted mux field

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [5:0] RST_START = 6'h00;
    localparam logic [5:0] RST_MUX = 6'h3F;
    localparam logic [5:0] RST_OFFSET = 6'h00;
    localparam logic [3:0] RST_DIV = 4'h0;
    localparam logic [3:0] RST_OSC = 4'h8;
    localparam logic [3:0] RST_PH1 = 4'h2;
    localparam logic [3:0] RST_PH2 = 4'h2;
    localparam logic RST_SEG_REV = 1'b0;         // column 0 on the first segment
    localparam logic RST_SCAN_DN = 1'b0;         // common scan upward
    localparam logic RST_COM_ALT = 1'b1;         // alternative pin layout
    localparam logic RST_COM_SWAP = 1'b0;        // no left/right swap

    // decoder states, one-hot
    typedef enum logic [1:0] {
        ST_OPCODE = 2'b01,
        ST_PARAM = 2'b10
    } dec_state_t;

    // decoded panel settings
    typedef struct packed {
        logic [5:0] start_line;
        logic seg_reverse;
        logic [5:0] mux_field;
        logic scan_down;
        logic [5:0] vert_offset;
        logic com_alt;
        logic com_swap;
        logic [3:0] clk_div;
        logic [3:0] osc_trim;
        logic [3:0] phase1;
        logic [3:0] phase2;
    } panel_cfg_t;

endpackage : panel_cfg_pkg

// [panel_cfg_cmds.sv]
// panel configuration and timing command decoder with apb slave
// assumes command bytes arrive by writes to the command register
`timescale 1ns/100ps

module panel_cfg_cmds (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output panel_cfg_pkg::panel_cfg_t cfg,
    output logic clk_div_en
);

    // ----------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------
    wire logic access = psel && penable;             // access phase, always ready
    wire logic wr_cmd = access && pwrite && (paddr == panel_cfg_pkg::OFF_CMD);
    wire logic hit_cmd = paddr == panel_cfg_pkg::OFF_CMD;
    wire logic hit_cfg0 = paddr == panel_cfg_pkg::OFF_CFG0;
    wire logic hit_cfg1 = paddr == panel_cfg_pkg::OFF_CFG1;
    wire logic hit_stat = paddr == panel_cfg_pkg::OFF_STAT;
    wire logic mapped = hit_cmd || hit_cfg0 || hit_cfg1 || hit_stat;
    wire logic [7:0] byte_in = pwdata[7:0];         // command or parameter byte

    panel_cfg_pkg::dec_state_t state;                // opcode or parameter phase
    logic [7:0] pending_op;                          // opcode awaiting its parameter
    logic [3:0] div_count;                           // display clock divider

    // true for opcodes that take one parameter byte
    function automatic logic takes_param(input logic [7:0] op);
        takes_param = (op == panel_cfg_pkg::OP_MUX) || (op == panel_cfg_pkg::OP_OFFSET)
            || (op == panel_cfg_pkg::OP_COMPINS) || (op == panel_cfg_pkg::OP_CLKDIV)
            || (op == panel_cfg_pkg::OP_PRECHG);
    endfunction : takes_param

    wire logic in_param = state == panel_cfg_pkg::ST_PARAM;
    wire logic op_wr = wr_cmd && !in_param;          // opcode byte written
    wire logic par_wr = wr_cmd && in_param;          // parameter byte written
    wire logic is_start = byte_in >= panel_cfg_pkg::OP_START_LO
        && byte_in <= panel_cfg_pkg::OP_START_HI;
    wire logic mux_ok = byte_in[5:0] >= panel_cfg_pkg::MUX_MIN_VALID;
    wire logic ph1_ok = byte_in[3:0] != 4'h0;
    wire logic ph2_ok = byte_in[7:4] != 4'h0;

    // ----------------------------------------------------------
    // command state machine
    // ----------------------------------------------------------
    // byte after a parameter opcode is its parameter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= panel_cfg_pkg::ST_OPCODE;
            pending_op <= 8'h00;
        end else begin
            case (state)
                panel_cfg_pkg::ST_OPCODE: begin
                    if (op_wr && takes_param(byte_in)) begin
                        state <= panel_cfg_pkg::ST_PARAM;
                        pending_op <= byte_in;
                    end
                end
                panel_cfg_pkg::ST_PARAM: begin
                    if (par_wr) begin
                        state <= panel_cfg_pkg::ST_OPCODE;
                    end
                end
                default: begin
                    state <= panel_cfg_pkg::ST_OPCODE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------
    // single-byte commands
    // ----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.start_line <= panel_cfg_pkg::RST_START;
            cfg.seg_reverse <= panel_cfg_pkg::RST_SEG_REV;
            cfg.scan_down <= panel_cfg_pkg::RST_SCAN_DN;
        end else if (op_wr) begin
            if (is_start) begin
                cfg.start_line <= byte_in[5:0];
            end
            if (byte_in == panel_cfg_pkg::OP_SEG_NORM) begin
                cfg.seg_reverse <= 1'b0;
            end
            if (byte_in == panel_cfg_pkg::OP_SEG_REV) begin
                cfg.seg_reverse <= 1'b1;
            end
            if (byte_in == panel_cfg_pkg::OP_SCAN_UP) begin
                cfg.scan_down <= 1'b0;
            end
            if (byte_in == panel_cfg_pkg::OP_SCAN_DN) begin
                cfg.scan_down <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------
    // parameter commands
    // ----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.mux_field <= panel_cfg_pkg::RST_MUX;
            cfg.vert_offset <= panel_cfg_pkg::RST_OFFSET;
            cfg.com_alt <= panel_cfg_pkg::RST_COM_ALT;
            cfg.com_swap <= panel_cfg_pkg::RST_COM_SWAP;
            cfg.clk_div <= panel_cfg_pkg::RST_DIV;
            cfg.osc_trim <= panel_cfg_pkg::RST_OSC;
            cfg.phase1 <= panel_cfg_pkg::RST_PH1;
            cfg.phase2 <= panel_cfg_pkg::RST_PH2;
        end else if (par_wr) begin
            case (pending_op)
                panel_cfg_pkg::OP_MUX: begin
                    if (mux_ok) begin
                        cfg.mux_field <= byte_in[5:0];
                    end
                end
                panel_cfg_pkg::OP_OFFSET: begin
                    cfg.vert_offset <= byte_in[5:0];
                end
                panel_cfg_pkg::OP_COMPINS: begin
                    cfg.com_alt <= byte_in[panel_cfg_pkg::ALT_BIT];
                    cfg.com_swap <= byte_in[panel_cfg_pkg::SWAP_BIT];
                end
                panel_cfg_pkg::OP_CLKDIV: begin
                    cfg.clk_div <= byte_in[3:0];
                    cfg.osc_trim <= byte_in[7:4];
                end
                panel_cfg_pkg::OP_PRECHG: begin
                    if (ph1_ok) begin
                        cfg.phase1 <= byte_in[3:0];
                    end
                    if (ph2_ok) begin
                        cfg.phase2 <= byte_in[7:4];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------
    // display clock divider: enable pulse every clk_div+1 cycles
    // ----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= 4'h0;
            clk_div_en <= 1'b0;
        end else if (div_count >= cfg.clk_div) begin
            div_count <= 4'h0;
            clk_div_en <= 1'b1;
        end else begin
            div_count <= div_count + 4'h1;
            clk_div_en <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // apb read data and response, registered at setup
    // ----------------------------------------------------------
    wire logic [31:0] next_prdata = hit_cfg0 ? {14'h0000, cfg.vert_offset, cfg.mux_field,
        cfg.start_line} : hit_cfg1 ? {12'h000, cfg.phase2, cfg.phase1, cfg.osc_trim,
        cfg.clk_div, cfg.com_swap, cfg.com_alt, cfg.scan_down, cfg.seg_reverse} :
        hit_stat ? {16'h0000, pending_op, 6'h00, state} : 32'h0000_0000;
    wire logic rd_setup = psel && !penable && !pwrite;  // read setup cycle

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // captured at setup so the word stands through the access cycle
            prdata <= rd_setup ? next_prdata : prdata;
            pready <= psel && !penable;                       // one wait-free access
            pslverr <= psel && !penable && !mapped;
        end
    end

    // ----------------------------------------------------------
    // assertions
    // ----------------------------------------------------------
    property p_start;
        @(posedge pclk) disable iff (!presetn) (op_wr && is_start)
            |=> cfg.start_line == $past(byte_in[5:0]);
    endproperty
    a_start: assert property (p_start) else $error("start line not loaded");

    property p_seg;
        @(posedge pclk) disable iff (!presetn) (op_wr && byte_in == 8'hA1) |=> cfg.seg_reverse;
    endproperty
    a_seg: assert property (p_seg) else $error("segment reverse not set");

    property p_mux;
        @(posedge pclk) disable iff (!presetn) (par_wr && pending_op == 8'hA8 && mux_ok)
            |=> cfg.mux_field == $past(byte_in[5:0]);
    endproperty
    a_mux: assert property (p_mux) else $error("mux not loaded");

    property p_mux_bad;
        @(posedge pclk) disable iff (!presetn)
            (par_wr && pending_op == panel_cfg_pkg::OP_MUX && !mux_ok)
            |=> $stable(cfg.mux_field);
    endproperty
    a_mux_bad: assert property (p_mux_bad) else $error("invalid mux accepted");

    property p_scan;
        @(posedge pclk) disable iff (!presetn) (op_wr && byte_in == 8'hC8) |=> cfg.scan_down;
    endproperty
    a_scan: assert property (p_scan) else $error("scan direction not set");

    property p_offset;
        @(posedge pclk) disable iff (!presetn) (par_wr && pending_op == 8'hD3)
            |=> cfg.vert_offset == $past(byte_in[5:0]);
    endproperty
    a_offset: assert property (p_offset) else $error("offset not loaded");

    property p_pins;
        @(posedge pclk) disable iff (!presetn) (par_wr && pending_op == 8'hDA)
            |=> cfg.com_alt == $past(byte_in[4]) && cfg.com_swap == $past(byte_in[5]);
    endproperty
    a_pins: assert property (p_pins) else $error("pin layout not loaded");

    property p_clk;
        @(posedge pclk) disable iff (!presetn) (par_wr && pending_op == 8'hD5)
            |=> {cfg.osc_trim, cfg.clk_div} == $past(byte_in);
    endproperty
    a_clk: assert property (p_clk) else $error("clock byte not loaded");

    property p_ph;
        @(posedge pclk) disable iff (!presetn) cfg.phase1 != 4'h0 && cfg.phase2 != 4'h0;
    endproperty
    a_ph: assert property (p_ph) else $error("zero pre-charge phase");

    property p_seg_norm;
        @(posedge pclk) disable iff (!presetn)
            (op_wr && byte_in == panel_cfg_pkg::OP_SEG_NORM) |=> !cfg.seg_reverse;
    endproperty
    a_seg_norm: assert property (p_seg_norm) else $error("segment map not normal");

    property p_scan_up;
        @(posedge pclk) disable iff (!presetn)
            (op_wr && byte_in == panel_cfg_pkg::OP_SCAN_UP) |=> !cfg.scan_down;
    endproperty
    a_scan_up: assert property (p_scan_up) else $error("scan not upward");

    property p_swap;
        @(posedge pclk) disable iff (!presetn) (par_wr && pending_op == panel_cfg_pkg::OP_COMPINS)
            |=> cfg.com_swap == $past(byte_in[panel_cfg_pkg::SWAP_BIT]);
    endproperty
    a_swap: assert property (p_swap) else $error("swap bit not loaded");

    // a pulse never lasts two cycles once the divide ratio is above one
    property p_div;
        @(posedge pclk) disable iff (!presetn) (clk_div_en && cfg.clk_div != 4'h0) |=> !clk_div_en;
    endproperty
    a_div: assert property (p_div) else $error("divider pulse too long");

    property p_ph1;
        @(posedge pclk) disable iff (!presetn)
            (par_wr && pending_op == panel_cfg_pkg::OP_PRECHG && ph1_ok)
            |=> cfg.phase1 == $past(byte_in[3:0]);
    endproperty
    a_ph1: assert property (p_ph1) else $error("phase 1 not loaded");

    property p_ph2_keep;
        @(posedge pclk) disable iff (!presetn)
            (par_wr && pending_op == panel_cfg_pkg::OP_PRECHG && !ph2_ok) |=> $stable(cfg.phase2);
    endproperty
    a_ph2_keep: assert property (p_ph2_keep) else $error("zero phase 2 accepted");

    property p_param;
        @(posedge pclk) disable iff (!presetn)
            (op_wr && takes_param(byte_in)) |=> in_param && pending_op == $past(byte_in);
    endproperty
    a_param: assert property (p_param) else $error("parameter wait not entered");

    // a parameter byte never acts as a single-byte command
    property p_par_only;
        @(posedge pclk) disable iff (!presetn) par_wr |=> $stable(cfg.start_line)
            && $stable(cfg.seg_reverse) && $stable(cfg.scan_down);
    endproperty
    a_par_only: assert property (p_par_only) else $error("parameter taken as opcode");

    c_scan_dn: cover property (@(posedge pclk) op_wr && byte_in == panel_cfg_pkg::OP_SCAN_DN);

    c_mux: cover property (@(posedge pclk) par_wr && pending_op == 8'hA8);
    c_pre: cover property (@(posedge pclk) par_wr && pending_op == 8'hD9);
    c_start: cover property (@(posedge pclk) op_wr && is_start);

endmodule : panel_cfg_cmds

// [panel_host_model.sv]
// host model: apb master issuing command and parameter bytes
// assumes one clock; the slave may insert any number of wait states
`timescale 1ns/100ps

module panel_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ----------------------------------------------------------
    // idle bus at time zero
    // ----------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'hA5A5A5A5;
    end

    // one transfer: setup, access held until pready, then release
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
            output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // wait states: the bench watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        // released lines no longer show the old values
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~data;
        @(posedge pclk);
    endtask : xfer
endmodule : panel_host_model

// [tb.sv]
// testbench for the panel configuration command decoder
// assumes the host model drives apb; cfg settles one cycle after a write
`timescale 1ns/100ps

module tb;
    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic clk_div_en;
    panel_cfg_pkg::panel_cfg_t cfg;
    panel_cfg_pkg::panel_cfg_t exp_cfg; // expected settings
    int errors;
    int checks;

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    panel_cfg_cmds uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg(cfg), .clk_div_en(clk_div_en));
    panel_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one byte to the command register, then let cfg settle
    task automatic send(input logic [7:0] b);
        logic [31:0] rd;
        logic er;
        host.xfer(1'b1, panel_cfg_pkg::OFF_CMD, {24'h000000, b}, rd, er);
        @(posedge pclk);
    endtask : send

    // compare cfg port and both readback registers with expectation
    task automatic cmp_cfg;
        logic [31:0] rd;
        logic er;
        check("cfg", 64'(exp_cfg), 64'(cfg));
        host.xfer(1'b0, panel_cfg_pkg::OFF_CFG0, 32'h00000000, rd, er);
        check("cfg0", {46'h0, exp_cfg.vert_offset, exp_cfg.mux_field, exp_cfg.start_line},
            {32'h0, rd});
        check("cfg0 err", 64'h0, {63'h0, er});
        host.xfer(1'b0, panel_cfg_pkg::OFF_CFG1, 32'h00000000, rd, er);
        check("cfg1", {44'h0, exp_cfg.phase2, exp_cfg.phase1, exp_cfg.osc_trim,
            exp_cfg.clk_div, exp_cfg.com_swap, exp_cfg.com_alt, exp_cfg.scan_down,
            exp_cfg.seg_reverse}, {32'h0, rd});
    endtask : cmp_cfg

    // read the decoder state word and compare it
    task automatic cmp_stat(input logic [7:0] op, input logic [1:0] st);
        logic [31:0] rd;
        logic er;
        host.xfer(1'b0, panel_cfg_pkg::OFF_STAT, 32'h00000000, rd, er);
        check("stat", {48'h0, op, 6'h00, st}, {32'h0, rd});
    endtask : cmp_stat

    // count divider enables over n cycles
    task automatic count_en(input int n, input logic [63:0] exp);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            if (clk_div_en === 1'b1) c++;
        end
        check("divider enables", exp, 64'(c));
    endtask : count_en

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_reset;
        exp_cfg = '0;
        exp_cfg.mux_field = 6'h3F;
        exp_cfg.com_alt = 1'b1;
        exp_cfg.osc_trim = 4'h8;
        exp_cfg.phase1 = 4'h2;
        exp_cfg.phase2 = 4'h2;
        cmp_cfg();
        count_en(8, 64'd8);
    endtask : t_reset

    task automatic t_start;
        logic [7:0] v [3] = '{8'h40, 8'h7F, 8'h55};
        foreach (v[i]) begin
            send(v[i]);
            exp_cfg.start_line = v[i][5:0];
            cmp_cfg();
        end
    endtask : t_start

    task automatic t_seg_scan;
        send(8'hA1);
        send(8'hC8);
        exp_cfg.seg_reverse = 1'b1;
        exp_cfg.scan_down = 1'b1;
        cmp_cfg();
        send(8'hA0);
        send(8'hC0);
        exp_cfg.seg_reverse = 1'b0;
        exp_cfg.scan_down = 1'b0;
        cmp_cfg();
    endtask : t_seg_scan

    task automatic t_mux;
        send(8'hA8);
        cmp_stat(8'hA8, panel_cfg_pkg::ST_PARAM);
        send(8'h0F);
        exp_cfg.mux_field = 6'h0F;
        cmp_cfg();
        send(8'hA8);
        send(8'h0E);
        cmp_cfg();
        send(8'hA8);
        send(8'hD0);
        exp_cfg.mux_field = 6'h10;
        cmp_cfg();
    endtask : t_mux

    // parameter bytes that look like opcodes must be taken as parameters
    task automatic t_offset;
        send(8'hD3);
        send(8'h7F);
        exp_cfg.vert_offset = 6'h3F;
        cmp_cfg();
        send(8'hD3);
        send(8'hC5);
        exp_cfg.vert_offset = 6'h05;
        cmp_cfg();
    endtask : t_offset

    task automatic t_pins;
        send(8'hDA);
        send(8'h22);
        exp_cfg.com_alt = 1'b0;
        exp_cfg.com_swap = 1'b1;
        cmp_cfg();
        send(8'hDA);
        send(8'h12);
        exp_cfg.com_alt = 1'b1;
        exp_cfg.com_swap = 1'b0;
        cmp_cfg();
    endtask : t_pins

    task automatic t_clock;
        send(8'hD5);
        send(8'hF3);
        exp_cfg.clk_div = 4'h3;
        exp_cfg.osc_trim = 4'hF;
        cmp_cfg();
        count_en(20, 64'd5);
    endtask : t_clock

    task automatic t_precharge;
        send(8'hD9);
        send(8'h5A);
        exp_cfg.phase1 = 4'hA;
        exp_cfg.phase2 = 4'h5;
        cmp_cfg();
        send(8'hD9);
        send(8'h07);
        exp_cfg.phase1 = 4'h7;
        cmp_cfg();
        send(8'hD9);
        send(8'h30);
        exp_cfg.phase2 = 4'h3;
        cmp_cfg();
    endtask : t_precharge

    // read-only write ignored, unmapped address flagged
    task automatic t_bus;
        logic [31:0] rd;
        logic er;
        host.xfer(1'b1, panel_cfg_pkg::OFF_CFG0, 32'hFFFFFFFF, rd, er);
        check("cfg0 write err", 64'h0, {63'h0, er});
        @(posedge pclk);
        cmp_cfg();
        host.xfer(1'b0, 8'h10, 32'h00000000, rd, er);
        check("unmapped err", 64'h1, {63'h0, er});
    endtask : t_bus

    // reset in mid-run while a parameter is awaited
    task automatic t_midreset;
        send(8'hA8);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        cmp_stat(8'h00, panel_cfg_pkg::ST_OPCODE);
        // after reset this byte is an unknown opcode, not a mux parameter
        send(8'h20);
        cmp_cfg();
    endtask : t_midreset

    // ----------------------------------------------------------
    // verdict, watchdog and main sequence
    // ----------------------------------------------------------
    task automatic give_verdict;
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (3000) @(posedge pclk);
        errors++;
        give_verdict();
    end

    initial begin
        errors = 0;
        checks = 0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_start();
        t_seg_scan();
        t_mux();
        t_offset();
        t_pins();
        t_clock();
        t_precharge();
        t_bus();
        t_midreset();
        give_verdict();
    end
endmodule : tb
